// ==== rpbc_bank.sv ====
/*
 Per-port back-channel configuration bank with port-select steering.
 Assumes a byte register access port from the local I2C slave and one
 from the link-side control channel; strap and power-down pins are async.
*/
`timescale 1ns/100ps
module rpbc_bank
	import rpbc_pkg::*;
#(
	parameter int NUM_PORTS = 2
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Pins
	input wire logic powerdown_release_pin,
	input wire logic [2:0] rateStrapPins,
	// Register access port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic regFromLink,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regHit,
	// Self-test error events per port
	input wire logic [NUM_PORTS-1:0] selfTestErr,
	input wire logic [NUM_PORTS-1:0] selfTestStart,
	// I2C transaction forwarding
	input wire logic i2cAddrMatch,
	input wire logic i2cIsWrite,
	input wire logic fwdLock,
	input wire logic remoteAck,
	// Per-port back-channel controls
	output logic [NUM_PORTS-1:0] fwdI2c,
	output logic [NUM_PORTS-1:0] localAck,
	output logic [NUM_PORTS-1:0] back_channel_en,
	output logic [NUM_PORTS-1:0] back_channel_check_gen_en,
	output logic [3*NUM_PORTS-1:0] back_channel_rate_sel,
	output logic [3*NUM_PORTS-1:0] rateSpeedCode,
	output logic [NUM_PORTS-1:0] rateReserved
);
	logic [1:0] pdbSync_ff;
	logic pdbLast_ff;
	logic [2:0] strapMeta_ff;
	logic [2:0] strapSync_ff;
	logic strapLoad;
	logic [7:0] portSel_ff;
	logic [7:0] rdData_ff;
	logic [NUM_PORTS-1:0] portOn;
	logic [7:0] setupQ [NUM_PORTS];
	logic [7:0] tallyQ [NUM_PORTS];
	// Port 0 owns the bank after reset
	localparam logic [7:0] PORT_SEL_RST = 8'h01;

	// --------------------------------------------------------------------
	// Pin synchronisers and strap capture
	// --------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pdbSync_ff <= 2'h0;
			pdbLast_ff <= 1'b0;
			strapMeta_ff <= 3'h0;
			strapSync_ff <= 3'h0;
		end
		else
		begin
			pdbSync_ff <= {pdbSync_ff[0], powerdown_release_pin};
			pdbLast_ff <= pdbSync_ff[1];
			strapMeta_ff <= rateStrapPins;
			strapSync_ff <= strapMeta_ff;
		end
	end

	// Rising edge of the release pin loads the strap rate
	assign strapLoad = pdbSync_ff[1] && !pdbLast_ff; // [RL9]

	// --------------------------------------------------------------------
	// Port select, one bit per port
	// --------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			portSel_ff <= PORT_SEL_RST;
		else if (regWrEn && regAddr == RPBC_OFS_PORT_SEL)
			portSel_ff <= regWrData;
	end

	// --------------------------------------------------------------------
	// Per-port copies and back-channel controls
	// --------------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++)
		begin : g_port
			logic sel;
			logic [2:0] rate;
			assign sel = portSel_ff[gp]; // [RL1]
			assign rate = setupQ[gp][RPBC_RATE_MSB:0];

			rpbc_port_regs u_regs (
				.clk_sys(clk_sys),
				.srst(srst),
				.strapLoad(strapLoad),
				.strapRate(strapSync_ff),
				.wrSetup(regWrEn && sel && regAddr == RPBC_OFS_SETUP), // [RL1]
				.wrFromLocal(!regFromLink),
				.wrData(regWrData),
				.tallyClear(selfTestStart[gp]),
				.tallyInc(selfTestErr[gp]),
				.setupQ(setupQ[gp]),
				.tallyQ(tallyQ[gp])
			);

			// Either pass-through mode keeps forwarding possible
			assign fwdI2c[gp] = setupQ[gp][RPBC_BIT_PASS_ALL] // [RL2]
				|| (setupQ[gp][RPBC_BIT_PASS_MATCH] && i2cAddrMatch); // [RL3]
			// Auto-ack ignores lock and remote ack on writes
			assign localAck[gp] = i2cIsWrite && (setupQ[gp][RPBC_BIT_AUTO_ACK] // [RL4]
				|| (fwdLock && remoteAck));
			assign portOn[gp] = setupQ[gp][RPBC_BIT_FORCE_ON] // [RL5]
				|| setupQ[gp][RPBC_BIT_PASS_ALL]
				|| setupQ[gp][RPBC_BIT_PASS_MATCH]; // [RL6]
			assign back_channel_en[gp] = portOn[gp];
			assign back_channel_check_gen_en[gp] = setupQ[gp][RPBC_BIT_CHECK_GEN]; // [RL8]
			// Rate applies at once; link may see brief errors on change
			assign back_channel_rate_sel[3*gp +: 3] = rate; // [RL11]

			always_comb
			begin
				rateReserved[gp] = 1'b0;
				case (rate) // [RL10]
					RPBC_RATE_2M5: rateSpeedCode[3*gp +: 3] = RPBC_SPD_2M5;
					RPBC_RATE_10M: rateSpeedCode[3*gp +: 3] = RPBC_SPD_10M;
					RPBC_RATE_25M: rateSpeedCode[3*gp +: 3] = RPBC_SPD_25M;
					RPBC_RATE_50M: rateSpeedCode[3*gp +: 3] = RPBC_SPD_50M;
					default:
					begin
						rateSpeedCode[3*gp +: 3] = RPBC_SPD_RSVD;
						rateReserved[gp] = 1'b1;
					end
				endcase
			end
		end
	endgenerate

	// --------------------------------------------------------------------
	// Read path: lowest selected port answers when several are selected
	// --------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			rdData_ff <= RPBC_ZERO8;
		else if (regRdEn)
		begin
			rdData_ff <= RPBC_ZERO8;
			if (regAddr == RPBC_OFS_PORT_SEL)
				rdData_ff <= portSel_ff;
			else if (regAddr == RPBC_OFS_ERR_TALLY || regAddr == RPBC_OFS_SETUP)
			begin
				for (int i = NUM_PORTS - 1; i >= 0; i--)
				begin
					if (portSel_ff[i]) // [RL1]
						rdData_ff <= (regAddr == RPBC_OFS_SETUP) ? setupQ[i] : tallyQ[i];
				end
			end
		end
	end

	assign regRdData = rdData_ff;
	assign regHit = regAddr == RPBC_OFS_PORT_SEL || regAddr == RPBC_OFS_ERR_TALLY
		|| regAddr == RPBC_OFS_SETUP;
endmodule

// ==== rpbc_pkg.sv ====
/*
 Package for the per-port back-channel register bank: offsets, field positions,
 reset values and rate codes. Assumes a single 50 MHz clock domain.
*/
// Notes on behaviour
// [RL1] Each receive port has its own register copy, chosen by port-select.
// [RL2] Bit 7 set forwards every I2C transaction to the remote serializer.
// [RL3] Bit 6 set forwards a transaction only when its address decode matches.
// [RL4] Bit 5 set acknowledges every I2C write locally, ignoring lock and remote ack.
// [RL5] Force-on bit 4, default one, keeps the back channel enabled.
// [RL6] With force-on clear, back channel enabled only while a pass-through bit is set.
// [RL7] Force-on bit writable only from the local I2C controller, not the link.
// [RL8] Bit 3, default one, enables the back-channel check generator.
// [RL9] Rate field reset value comes from straps sampled at power-down release.
// [RL10] Rate codes: 000 2.5, 010 10, 101 25, 110 50 Mbps; others reserved.
// [RL11] A rate change may briefly cause back-channel errors; both sides tolerate it.
// [RL12] Remote side should enter auto-acknowledge before a link-side rate change.
package rpbc_pkg;
	localparam logic [7:0] RPBC_OFS_PORT_SEL = 8'h4C;
	localparam logic [7:0] RPBC_OFS_ERR_TALLY = 8'h57;
	localparam logic [7:0] RPBC_OFS_SETUP = 8'h58;
	localparam int RPBC_BIT_PASS_ALL = 7;
	localparam int RPBC_BIT_PASS_MATCH = 6;
	localparam int RPBC_BIT_AUTO_ACK = 5;
	localparam int RPBC_BIT_FORCE_ON = 4;
	localparam int RPBC_BIT_CHECK_GEN = 3;
	localparam int RPBC_RATE_MSB = 2;
	localparam logic [4:0] RPBC_SETUP_UPPER_RST = 5'h03;
	localparam logic [7:0] RPBC_TALLY_RST = 8'h00;
	localparam logic [2:0] RPBC_RATE_2M5 = 3'h0;
	localparam logic [2:0] RPBC_RATE_10M = 3'h2;
	localparam logic [2:0] RPBC_RATE_25M = 3'h5;
	localparam logic [2:0] RPBC_RATE_50M = 3'h6;
	localparam logic [7:0] RPBC_ZERO8 = 8'h00;
	typedef enum logic [2:0] {
		RPBC_SPD_2M5,
		RPBC_SPD_10M,
		RPBC_SPD_25M,
		RPBC_SPD_50M,
		RPBC_SPD_RSVD
	} rpbc_speed_t;
endpackage

// ==== rpbc_port_regs.sv ====
/*
 One receive port's copy of the error tally and back-channel setup register.
 Assumes writes already qualified by port selection and sampled straps.
*/
`timescale 1ns/100ps
module rpbc_port_regs
	import rpbc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Strap load
	input wire logic strapLoad,
	input wire logic [2:0] strapRate,
	// Register writes
	input wire logic wrSetup,
	input wire logic wrFromLocal,
	input wire logic [7:0] wrData,
	// Self-test error events
	input wire logic tallyClear,
	input wire logic tallyInc,
	// Register contents
	output logic [7:0] setupQ,
	output logic [7:0] tallyQ
);
	logic [7:0] setup_ff;
	logic [7:0] tally_ff;
	logic [7:0] nxt_setup;
	// Saturate rather than wrap so a long run never reads as clean
	localparam logic [7:0] TALLY_MAX = 8'hFF;

	// --------------------------------------------------------------------
	// Setup register
	// --------------------------------------------------------------------
	always_comb
	begin
		nxt_setup = setup_ff;
		if (wrSetup)
		begin
			nxt_setup = wrData;
			if (!wrFromLocal)
				nxt_setup[RPBC_BIT_FORCE_ON] = setup_ff[RPBC_BIT_FORCE_ON]; // [RL7]
		end
		if (strapLoad)
			nxt_setup[RPBC_RATE_MSB:0] = strapRate; // [RL9]
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			setup_ff <= {RPBC_SETUP_UPPER_RST, RPBC_RATE_2M5}; // [RL5] [RL8]
		else
			setup_ff <= nxt_setup;
	end

	// --------------------------------------------------------------------
	// Error tally, saturating
	// --------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst || tallyClear)
			tally_ff <= RPBC_TALLY_RST;
		else if (tallyInc && tally_ff != TALLY_MAX)
			tally_ff <= tally_ff + 8'h01;
	end

	assign setupQ = setup_ff;
	assign tallyQ = tally_ff;
endmodule

// ==== rpbc_far_model.sv ====
/* Remote serializer stand-in: lock plus a late acknowledge.
 Assumes the bank's port-0 forward request and the bench clock. */
`timescale 1ns/100ps
module rpbc_far_model
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Link side
	input wire logic fwdReq,
	output logic fwdLock_ff,
	output logic remoteAck_ff
);
	// Ack lags one cycle, a slow remote; rate-change errors are tolerated
	always_ff @(posedge clk_sys)
	begin
		fwdLock_ff <= !srst;
		remoteAck_ff <= fwdReq & !srst;
	end
endmodule

// ==== rpbc_bank_properties.sv ====
/* Port-level checks of the back-channel bank, port 0; reset and check-gen checks cover all ports.
 Assumes binding to rpbc_bank, one clock, synchronous reset. */
`timescale 1ns/100ps
module rpbc_bank_properties
	import rpbc_pkg::*;
#(
	parameter int NUM_PORTS = 2
)
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regRdData,
	input wire logic regHit,
	input wire logic i2cIsWrite,
	input wire logic fwdLock,
	input wire logic remoteAck,
	input wire logic [NUM_PORTS-1:0] fwdI2c,
	input wire logic [NUM_PORTS-1:0] localAck,
	input wire logic [NUM_PORTS-1:0] back_channel_en,
	input wire logic [NUM_PORTS-1:0] back_channel_check_gen_en,
	input wire logic [3*NUM_PORTS-1:0] back_channel_rate_sel,
	input wire logic [3*NUM_PORTS-1:0] rateSpeedCode,
	input wire logic [NUM_PORTS-1:0] rateReserved
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_missRd;
		regRdEn && !regHit;
	endsequence
	property p_hit; regHit == (regAddr inside {8'h4C, 8'h57, 8'h58}); endproperty
	a_hit: assert property (p_hit) else $error("hit decode wrong");
	property p_rdz; s_missRd |=> regRdData == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
	property p_fwd; fwdI2c[0] |-> back_channel_en[0]; endproperty
	a_fwd: assert property (p_fwd) else $error("forwarding without channel");
	property p_ackw; localAck[0] |-> i2cIsWrite; endproperty
	a_ackw: assert property (p_ackw) else $error("ack on a read");
	property p_ackr; i2cIsWrite && fwdLock && remoteAck |-> localAck[0]; endproperty
	a_ackr: assert property (p_ackr) else $error("remote ack lost");
	property p_rst; $fell(srst) |-> back_channel_en == '1 && back_channel_check_gen_en == '1;
	endproperty
	a_rst: assert property (p_rst) else $error("reset defaults wrong");
	property p_rsv;
		rateReserved[0] == (back_channel_rate_sel[2:0] inside {3'h1, 3'h3, 3'h4, 3'h7});
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved rate flag wrong");
	property p_spd; back_channel_rate_sel[2:0] == RPBC_RATE_50M |-> rateSpeedCode[2:0] == 3'h3;
	endproperty
	a_spd: assert property (p_spd) else $error("fast rate code wrong");
	property p_chk; $changed(back_channel_check_gen_en) |-> $past(regWrEn); endproperty
	a_chk: assert property (p_chk) else $error("check gen moved alone");
endmodule
bind rpbc_bank rpbc_bank_properties #(.NUM_PORTS(NUM_PORTS)) u_prop (.clk_sys, .srst,
	.regWrEn, .regRdEn, .regAddr, .regRdData, .regHit, .i2cIsWrite, .fwdLock, .remoteAck,
	.fwdI2c, .localAck, .back_channel_en, .back_channel_check_gen_en, .back_channel_rate_sel,
	.rateSpeedCode, .rateReserved);

// ==== tb_rpbc_bank.sv ====
/* Register-level bench of the back-channel bank with a remote stand-in.
 Assumes two ports and the far model for lock and acknowledge. */
`timescale 1ns/100ps
module tb_rpbc_bank;
	import rpbc_pkg::*;
	logic clk_sys = 1'h0, srst = 1'h1, powerdown_release_pin = 1'h0, regWrEn = 1'h0;
	logic regRdEn = 1'h0, regFromLink = 1'h0, i2cAddrMatch = 1'h0, i2cIsWrite = 1'h1;
	logic [2:0] rateStrapPins = 3'h0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
	logic [1:0] selfTestErr = 2'h0, selfTestStart = 2'h0;
	logic [2:0] spx [8] = '{3'h0, 3'h4, 3'h1, 3'h4, 3'h4, 3'h2, 3'h3, 3'h4};
	wire logic [7:0] regRdData;
	wire logic regHit, fwdLock, remoteAck;
	wire logic [1:0] fwdI2c, localAck, back_channel_en, back_channel_check_gen_en, rateReserved;
	wire logic [5:0] back_channel_rate_sel, rateSpeedCode;
	// Port 0 controls packed {fwd, ack, en, gen}
	wire logic [7:0] ctl = {4'h0, fwdI2c[0], localAck[0], back_channel_en[0],
		back_channel_check_gen_en[0]};
	int n_errors = 0, total_checks = 0;
	rpbc_bank #(.NUM_PORTS(2)) dut (.clk_sys, .srst, .powerdown_release_pin, .rateStrapPins,
		.regWrEn, .regRdEn, .regFromLink, .regAddr, .regWrData, .regRdData, .regHit,
		.selfTestErr, .selfTestStart, .i2cAddrMatch, .i2cIsWrite, .fwdLock, .remoteAck,
		.fwdI2c, .localAck, .back_channel_en, .back_channel_check_gen_en,
		.back_channel_rate_sel, .rateSpeedCode, .rateReserved);
	rpbc_far_model far (.clk_sys, .srst, .fwdReq(fwdI2c[0]), .fwdLock_ff(fwdLock),
		.remoteAck_ff(remoteAck));
	initial
	begin
		forever #10 clk_sys = !clk_sys;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d, input logic l);
		@(posedge clk_sys);
		regWrEn <= 1'h1;
		regAddr <= a;
		regWrData <= d;
		regFromLink <= l;
		@(posedge clk_sys);
		regWrEn <= 1'h0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regRdEn <= 1'h1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 1'h0;
		#1 chk("rdData", regRdData, e);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run is well under two thousand cycles
	initial
	begin
		#100000 n_errors++;
		finish_test;
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		srst <= 1'h0;
		rdc(8'h58, 8'h18);
		chk("ctl", ctl, 8'h03);
		rdc(8'h57, 8'h00);
		rdc(8'h4C, 8'h01);
		rdc(8'h60, 8'h00);
		wrr(8'h58, 8'h00, 1'h0);
		chk("ctl", ctl, 8'h00);
		wrr(8'h58, 8'h50, 1'h1);
		rdc(8'h58, 8'h40);
		wrr(8'h58, 8'h40, 1'h0);
		chk("ctl", ctl, 8'h02);
		@(posedge clk_sys) i2cAddrMatch <= 1'h1;
		#1 chk("ctl", ctl, 8'h0A);
		wrr(8'h58, 8'h80, 1'h0);
		chk("ctl", ctl, 8'h0E);
		wrr(8'h58, 8'h20, 1'h0);
		chk("ctl", ctl, 8'h04);
		for (int i = 0; i < 8; i++)
		begin
			wrr(8'h58, {5'h03, 3'(i)}, 1'h0);
			chk("spd", {5'h00, rateSpeedCode[2:0]}, {5'h00, spx[i]});
			chk("rsv", {7'h00, rateReserved[0]}, {7'h00, spx[i] == 3'h4});
		end
		wrr(8'h4C, 8'h02, 1'h0);
		wrr(8'h58, 8'h06, 1'h0);
		rdc(8'h58, 8'h06);
		chk("rate1", {2'h0, back_channel_rate_sel}, 8'h37);
		chk("ctl1", {4'h0, back_channel_en, back_channel_check_gen_en}, 8'h05);
		chk("spd1", {2'h0, rateSpeedCode}, 8'h1C);
		chk("rsv1", {6'h00, rateReserved}, 8'h01);
		chk("fa1", {4'h0, fwdI2c, localAck}, 8'h00);
		wrr(8'h4C, 8'h01, 1'h0);
		rdc(8'h58, 8'h1F);
		@(posedge clk_sys) selfTestErr <= 2'h1;
		repeat (2) @(posedge clk_sys);
		selfTestErr <= 2'h0;
		rdc(8'h57, 8'h02);
		wrr(8'h57, 8'h55, 1'h0);
		rdc(8'h57, 8'h02);
		@(posedge clk_sys) selfTestStart <= 2'h1;
		@(posedge clk_sys) selfTestStart <= 2'h0;
		rdc(8'h57, 8'h00);
		wrr(8'h58, 8'h18, 1'h0);
		@(posedge clk_sys);
		rateStrapPins <= 3'h5;
		powerdown_release_pin <= 1'h1;
		repeat (5) @(posedge clk_sys);
		rdc(8'h58, 8'h1D);
		finish_test;
	end
endmodule
